// ==== rtl/sbd_cfg.svh ====
// Constants of the sideband block: map, fields, resets, timing.
// Assumes a 100 MHz clock and a 32-bit Wishbone bus.
`ifndef SBD_CFG_SVH
`define SBD_CFG_SVH

// ****************************************************************
// Clock and timing
// ****************************************************************
`define SBD_CLK_MHZ        100
`define SBD_TICK_US        1000
`define SBD_TICK_CYCLES    (`SBD_TICK_US * `SBD_CLK_MHZ)
`define SBD_SLOW_PERIOD_MS 2000
`define SBD_SLOW_ON_PCT    20
`define SBD_FAST_PERIOD_MS 500
`define SBD_FAST_ON_PCT    50
`define SBD_STAGGER_MS     12000
`define SBD_MS_TO_TICKS(ms) (((ms) * 1000) / `SBD_TICK_US)
`define SBD_SETTLE_CYCLES  2'h3

// ****************************************************************
// Register map (byte addresses)
// ****************************************************************
`define SBD_REG_CTRL   8'h00
`define SBD_REG_STATUS 8'h04

// ****************************************************************
// Control fields
// ****************************************************************
`define SBD_CTRL_FAULT_CMD  0
`define SBD_CTRL_INT_FAIL   1
`define SBD_CTRL_SELFTEST   2
`define SBD_CTRL_CMD_ACTIVE 3
`define SBD_CTRL_FORMAT     4
`define SBD_CTRL_SPIN_LO    5
`define SBD_CTRL_SPIN_HI    6
`define SBD_CTRL_ESI_REQ    7
`define SBD_CTRL_START_CMD  8
`define SBD_CTRL_RESET      9'h000

// ****************************************************************
// Status fields
// ****************************************************************
`define SBD_STAT_SLOT_LO   0
`define SBD_STAT_SLOT_HI   6
`define SBD_STAT_SOFT      7
`define SBD_STAT_INVALID   8
`define SBD_STAT_MODE_LO   9
`define SBD_STAT_MODE_HI   10
`define SBD_STAT_SPIN_REQ  11
`define SBD_STAT_SKIP_LO   12
`define SBD_STAT_SKIP_HI   13
`define SBD_STAT_FAULT     14
`define SBD_STAT_ACTIVITY  15
`define SBD_STAT_LIVE_LO   16
`define SBD_STAT_LIVE_HI   22
`define SBD_STAT_CAPTURED  23

// ****************************************************************
// Slot codes and reset values
// ****************************************************************
`define SBD_SLOT_LAST_HARD 7'h7d
`define SBD_SLOT_NO_NODE   7'h7e
`define SBD_SLOT_SOFT      7'h7f
`define SBD_SLOT_MOD_MASK  7'h07
`define SBD_SKIP_RESET     2'h3

`endif

// ==== rtl/sbd_pkg.sv ====
// Types shared by the drive backplane sideband block.
// Needs none of the constants of sbd_cfg.svh; holds its own enum codes and widths.
package sbd_pkg;

	// Spindle state reported by the drive firmware
	typedef enum logic [1:0]
	{
		SPIN_STOPPED  = 2'h0,
		SPIN_ACCEL    = 2'h1,
		SPIN_AT_SPEED = 2'h2,
		SPIN_DECEL    = 2'h3
	} sbd_spindle_type;

	// Motor start strap decode, {second, first}
	typedef enum logic [1:0]
	{
		START_POWER_ON = 2'h0,
		START_STAGGER  = 2'h1,
		START_COMMAND  = 2'h2,
		START_NEVER    = 2'h3
	} sbd_start_mode_type;

	// Spin-up sequencer, one-hot
	typedef enum logic [4:0]
	{
		SEQ_CAPTURE  = 5'h01,
		SEQ_DELAY    = 5'h02,
		SEQ_WAIT_CMD = 5'h04,
		SEQ_RUN      = 5'h08,
		SEQ_NEVER    = 5'h10
	} sbd_seq_type;

	// Per-port loop events and failure levels from the link logic
	typedef struct packed
	{
		logic skip_prim;     // Loop port bypass sequence seen, pulse
		logic enable_prim;   // Loop port enable sequence seen, pulse
		logic wrap_fail;     // Wrap test failed, level
		logic rx_clk_lost;   // Receive clock lost, level
		logic tx_clk_lost;   // Transmit clock lost, level
		logic hw_err;        // Interface hardware error, level
	} sbd_loop_evt_type;

	// Wishbone classic request
	typedef struct packed
	{
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  sel;
		logic [7:0]  adr;
		logic [31:0] dat;
	} sbd_wb_req_type;

endpackage

// ==== rtl/sbd_sideband.sv ====
// Drive backplane sideband logic: lamps, loop skip, straps, slot number.
// Assumes one clock, loop events on it; strap and slot pins are async.
//
// Function
// R1 - Failure lamp: both ports failed, internal failure or host command.
// R2 - Stopped, idle: activity lamp 20% on in 2 s.
// R3 - Stopped, command running: activity lamp on.
// R4 - At speed, idle: activity lamp on.
// R5 - At speed, command running: activity lamp off.
// R6 - Spinning up or down: activity lamp blinks 50% duty.
// R7 - Formatting: activity lamp inverts per cylinder change.
// R8 - Active-low skip output per port; low bypasses the drive.
// R9 - Skip indicator low while its skip output is active.
// R10 - Skip set by internal failure or loop port bypass sequence.
// R11 - Skipped port keeps its receiver running.
// R12 - Loop port enable sequence releases skip after self-test, no failure.
// R13 - Wrap failure, clock loss or hardware error force skip.
// R14 - Straps: both low power-on, second high command, both high never.
// R15 - Second low, first high: start after 12 s times slot modulo 8.
// R16 - Backplane holds motor start straps static.
// R17 - Backplane shows slot number while side channel high.
// R18 - Slot 00 to 7D valid addresses; 7E invalid.
// R19 - Slot 7F: soft address at loop initialisation.
// R20 - Backplane drives slot lines high and low; no pull-ups.
// R21 - Side channel low: services mode, support and mode discovered.
// R22 - Skip inputs pulled low through 1K at the switch.
// R23 - Side channel high by default, low only in services transfer.
// R24 - Slot lines sampled once after reset, then held.
// R25 - Format toggle and spindle blink beat steady lamp states.
//
// Chosen here: the Wishbone register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "sbd_cfg.svh"

module sbd_sideband
#(
	parameter int TICK_CYCLES = `SBD_TICK_CYCLES
)
(
	// Clock and reset
	input  wire logic                             clk,
	input  wire logic                             rst_b,
	// Wishbone classic slave
	input  wire sbd_pkg::sbd_wb_req_type          wb_req,
	output logic [31:0]                           wb_dat_o,
	output logic                                  wb_ack_o,
	// Loop events, index 0 is port A
	input  wire sbd_pkg::sbd_loop_evt_type [1:0]  loop_evt,
	input  wire logic                             cylinder_step,
	// Backplane pins
	input  wire logic                             start_strap_1,
	input  wire logic                             start_strap_2,
	input  wire logic [6:0]                       slot_number,
	output logic                                  enclosure_side_channel_n,
	output logic                                  failure_lamp_n,
	output logic                                  activity_lamp_n,
	output logic                                  loop_skip_a_n,
	output logic                                  loop_skip_b_n,
	output logic                                  skip_indicator_a_n,
	output logic                                  skip_indicator_b_n,
	// Drive-side controls
	output logic [1:0]                            loop_rx_enable,
	output logic [1:0]                            loop_tx_enable,
	output logic                                  spin_up_req,
	output logic [6:0]                            hard_address,
	output logic                                  hard_address_valid,
	output logic                                  soft_address_req
);

	// ****************************************************************
	// Functions
	// ****************************************************************

	// Lamp on while the phase counter is inside the on fraction
	function automatic logic blink_on(input logic [31:0] phase, input logic [31:0] on_len);
		blink_on = (phase < on_len);
	endfunction

	// Next phase of a free-running period counter
	function automatic logic [31:0] phase_next(input logic [31:0] phase,
		input logic [31:0] period);
		phase_next = (phase >= period - 32'h1) ? 32'h0 : phase + 32'h1;
	endfunction

	localparam logic [31:0] SLOW_PERIOD = `SBD_MS_TO_TICKS(`SBD_SLOW_PERIOD_MS);
	localparam logic [31:0] SLOW_ON     = SLOW_PERIOD * `SBD_SLOW_ON_PCT / 100;
	localparam logic [31:0] FAST_PERIOD = `SBD_MS_TO_TICKS(`SBD_FAST_PERIOD_MS);
	localparam logic [31:0] FAST_ON     = FAST_PERIOD * `SBD_FAST_ON_PCT / 100;
	localparam logic [31:0] STAGGER     = `SBD_MS_TO_TICKS(`SBD_STAGGER_MS);
	localparam logic [31:0] TICK_LAST   = TICK_CYCLES - 1;

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic [8:0]                     ctrl_q;
	logic                           start_cmd_q;
	logic                           ack_q;
	logic [31:0]                    dat_q;
	logic [8:0]                     pin_meta_q;
	logic [8:0]                     pin_sync_q;
	logic [1:0]                     settle_q;
	logic [6:0]                     slot_q;
	logic                           captured_q;
	sbd_pkg::sbd_start_mode_type    mode_q;
	sbd_pkg::sbd_seq_type           seq_q;
	logic [31:0]                    tick_cnt_q;
	logic                           tick;
	logic [31:0]                    slow_q;
	logic [31:0]                    fast_q;
	logic [31:0]                    delay_q;
	logic [31:0]                    delay_target;
	logic [1:0]                     skip_q;
	logic [1:0]                     port_fault_q;
	logic                           fault_on_q;
	logic                           act_on_q;
	logic                           act_on_d;
	logic                           wr_en;
	logic                           rd_en;
	logic [31:0]                    status;
	sbd_pkg::sbd_spindle_type       spindle;

	assign spindle = sbd_pkg::sbd_spindle_type'(ctrl_q[`SBD_CTRL_SPIN_HI:`SBD_CTRL_SPIN_LO]);

	// ****************************************************************
	// Wishbone slave
	// ****************************************************************

	// Answer one cycle after the strobe, drop ack the cycle after
	assign wr_en = wb_req.cyc & wb_req.stb & ~ack_q & wb_req.we;
	assign rd_en = wb_req.cyc & wb_req.stb & ~ack_q & ~wb_req.we;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			ack_q <= 1'b0;
		else
			ack_q <= wb_req.cyc & wb_req.stb & ~ack_q;
	end

	// Control register; unmapped writes are acked and dropped
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			ctrl_q <= `SBD_CTRL_RESET;
		else if (wr_en && wb_req.adr == `SBD_REG_CTRL)
		begin
			if (wb_req.sel[0])
				ctrl_q[7:0] <= wb_req.dat[7:0];
			if (wb_req.sel[1])
				ctrl_q[8] <= 1'b0; // Start bit is write-one, never stored here
		end
	end

	// Start command is sticky: once given the sequencer may run
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			start_cmd_q <= 1'b0;
		else if (wr_en && wb_req.adr == `SBD_REG_CTRL && wb_req.sel[1] &&
			wb_req.dat[`SBD_CTRL_START_CMD])
			start_cmd_q <= 1'b1;
	end

	// Status word gathers the block's own state
	always_comb
	begin
		status = 32'h0;
		status[`SBD_STAT_SLOT_HI:`SBD_STAT_SLOT_LO] = slot_q;
		status[`SBD_STAT_SOFT] = soft_address_req;
		status[`SBD_STAT_INVALID] = (slot_q == `SBD_SLOT_NO_NODE);
		status[`SBD_STAT_MODE_HI:`SBD_STAT_MODE_LO] = mode_q;
		status[`SBD_STAT_SPIN_REQ] = spin_up_req;
		status[`SBD_STAT_SKIP_HI:`SBD_STAT_SKIP_LO] = skip_q;
		status[`SBD_STAT_FAULT] = fault_on_q;
		status[`SBD_STAT_ACTIVITY] = act_on_q;
		status[`SBD_STAT_LIVE_HI:`SBD_STAT_LIVE_LO] = pin_sync_q[6:0];
		status[`SBD_STAT_CAPTURED] = captured_q;
	end

	// Read data registered with the ack; unmapped reads return zero
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			dat_q <= 32'h0;
		else if (rd_en)
		begin
			case (wb_req.adr)
				`SBD_REG_CTRL:   dat_q <= {23'h0, start_cmd_q, ctrl_q[7:0]};
				`SBD_REG_STATUS: dat_q <= status;
				default:         dat_q <= 32'h0;
			endcase
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;

	// ****************************************************************
	// Pin synchronisers and slot capture
	// ****************************************************************

	// Straps and slot lines are async; first stage feeds only the second
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pin_meta_q <= 9'h0;
			pin_sync_q <= 9'h0;
		end
		else
		begin
			pin_meta_q <= {start_strap_2, start_strap_1, slot_number};
			pin_sync_q <= pin_meta_q;
		end
	end

	// Wait for the synchronisers to fill, then take one sample
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			settle_q <= 2'h0;
		else if (settle_q != `SBD_SETTLE_CYCLES)
			settle_q <= settle_q + 2'h1;
	end

	// Slot number and straps held from the single sample onward
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			slot_q     <= 7'h0;
			mode_q     <= sbd_pkg::START_NEVER;
			captured_q <= 1'b0;
		end
		else if (!captured_q && settle_q == `SBD_SETTLE_CYCLES && enclosure_side_channel_n)
		begin
			slot_q     <= pin_sync_q[6:0]; // R24 R17
			mode_q     <= sbd_pkg::sbd_start_mode_type'(pin_sync_q[8:7]); // R14 R16
			captured_q <= 1'b1;
		end
	end

	// Address selection from the held slot number
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			hard_address       <= 7'h0;
			hard_address_valid <= 1'b0;
			soft_address_req   <= 1'b0;
		end
		else
		begin
			hard_address       <= slot_q;
			hard_address_valid <= captured_q && slot_q <= `SBD_SLOT_LAST_HARD; // R18
			soft_address_req   <= captured_q && slot_q == `SBD_SLOT_SOFT; // R19
		end
	end

	// Side channel stays high except while firmware runs a transfer
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			enclosure_side_channel_n <= 1'b1;
		else
			enclosure_side_channel_n <= ~(ctrl_q[`SBD_CTRL_ESI_REQ] & captured_q); // R23 R21
	end

	// ****************************************************************
	// Millisecond tick and blink phases
	// ****************************************************************

	// One-cycle enable every millisecond keeps long counts narrow
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			tick_cnt_q <= 32'h0;
		else if (tick)
			tick_cnt_q <= 32'h0;
		else
			tick_cnt_q <= tick_cnt_q + 32'h1;
	end

	assign tick = (tick_cnt_q >= TICK_LAST);

	// Two free-running phases; lamp picks one depending on spindle state
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			slow_q <= 32'h0;
			fast_q <= 32'h0;
		end
		else if (tick)
		begin
			slow_q <= phase_next(slow_q, SLOW_PERIOD);
			fast_q <= phase_next(fast_q, FAST_PERIOD);
		end
	end

	// ****************************************************************
	// Spin-up sequencer
	// ****************************************************************

	// Stagger delay in ticks; slot modulo 8 keeps it at most 84 s
	assign delay_target = STAGGER * {29'h0, slot_q[2:0] & 3'(`SBD_SLOT_MOD_MASK)}; // R15

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			delay_q <= 32'h0;
		else if (seq_q == sbd_pkg::SEQ_DELAY && tick)
			delay_q <= delay_q + 32'h1;
	end

	// Sequencer follows the strap mode captured after reset
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			seq_q <= sbd_pkg::SEQ_CAPTURE;
		else
		begin
			case (seq_q)
				sbd_pkg::SEQ_CAPTURE:
				begin
					if (captured_q)
					begin
						case (mode_q) // R14
							sbd_pkg::START_POWER_ON: seq_q <= sbd_pkg::SEQ_RUN;
							sbd_pkg::START_STAGGER:  seq_q <= sbd_pkg::SEQ_DELAY;
							sbd_pkg::START_COMMAND:  seq_q <= sbd_pkg::SEQ_WAIT_CMD;
							default:                 seq_q <= sbd_pkg::SEQ_NEVER;
						endcase
					end
				end
				sbd_pkg::SEQ_DELAY:
				begin
					if (delay_q >= delay_target) // R15
						seq_q <= sbd_pkg::SEQ_RUN;
				end
				sbd_pkg::SEQ_WAIT_CMD:
				begin
					if (start_cmd_q) // R14
						seq_q <= sbd_pkg::SEQ_RUN;
				end
				sbd_pkg::SEQ_RUN:   seq_q <= sbd_pkg::SEQ_RUN;
				sbd_pkg::SEQ_NEVER: seq_q <= sbd_pkg::SEQ_NEVER;
				default:            seq_q <= sbd_pkg::SEQ_CAPTURE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			spin_up_req <= 1'b0;
		else
			spin_up_req <= (seq_q == sbd_pkg::SEQ_RUN);
	end

	// ****************************************************************
	// Loop skip control
	// ****************************************************************

	// Skip starts active: self-test has not finished at reset
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			skip_q       <= `SBD_SKIP_RESET;
			port_fault_q <= 2'h0;
		end
		else
		begin
			for (int p = 0; p < 2; p++)
			begin
				// Set wins over release in the same cycle
				if (ctrl_q[`SBD_CTRL_INT_FAIL] || loop_evt[p].wrap_fail ||
					loop_evt[p].rx_clk_lost || loop_evt[p].tx_clk_lost ||
					loop_evt[p].hw_err || loop_evt[p].skip_prim)
					skip_q[p] <= 1'b1; // R10 R13
				else if (loop_evt[p].enable_prim && ctrl_q[`SBD_CTRL_SELFTEST])
					skip_q[p] <= 1'b0; // R12
				// Port failure memory for the failure lamp
				if (loop_evt[p].wrap_fail || loop_evt[p].rx_clk_lost ||
					loop_evt[p].tx_clk_lost || loop_evt[p].hw_err)
					port_fault_q[p] <= 1'b1; // R13
				else if (loop_evt[p].enable_prim && ctrl_q[`SBD_CTRL_SELFTEST])
					port_fault_q[p] <= 1'b0;
			end
		end
	end

	// Receivers never gated by skip so enable sequences still arrive
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			loop_rx_enable <= 2'h0;
			loop_tx_enable <= 2'h0;
		end
		else
		begin
			loop_rx_enable <= 2'h3; // R11
			loop_tx_enable <= ~skip_q;
		end
	end

	assign loop_skip_a_n      = ~skip_q[0]; // R8
	assign loop_skip_b_n      = ~skip_q[1]; // R8
	assign skip_indicator_a_n = ~skip_q[0]; // R9
	assign skip_indicator_b_n = ~skip_q[1]; // R9

	// ****************************************************************
	// Lamps
	// ****************************************************************

	// Failure lamp sinks current on host command, internal failure or both ports failed
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			fault_on_q <= 1'b0;
		else
			fault_on_q <= ctrl_q[`SBD_CTRL_FAULT_CMD] | ctrl_q[`SBD_CTRL_INT_FAIL] |
				(&port_fault_q); // R1
	end

	assign failure_lamp_n = ~fault_on_q;

	// Activity lamp; format toggling first, then spindle motion, then steady
	always_comb
	begin
		act_on_d = act_on_q;
		if (ctrl_q[`SBD_CTRL_FORMAT])
		begin
			if (cylinder_step)
				act_on_d = ~act_on_q; // R7 R25
		end
		else
		begin
			case (spindle)
				sbd_pkg::SPIN_ACCEL,
				sbd_pkg::SPIN_DECEL:
					act_on_d = blink_on(fast_q, FAST_ON); // R6 R25
				sbd_pkg::SPIN_STOPPED:
					if (ctrl_q[`SBD_CTRL_CMD_ACTIVE])
						act_on_d = 1'b1; // R3
					else
						act_on_d = blink_on(slow_q, SLOW_ON); // R2
				sbd_pkg::SPIN_AT_SPEED:
					act_on_d = ~ctrl_q[`SBD_CTRL_CMD_ACTIVE]; // R4 R5
				default:
					act_on_d = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			act_on_q <= 1'b0;
		else
			act_on_q <= act_on_d;
	end

	assign activity_lamp_n = ~act_on_q;

endmodule
`default_nettype wire

// ==== bench/sbd_sideband_sva.sv ====
// Checker bound to the sideband block; it sees the block's ports only.
// Assumes one clock domain and the active-low asynchronous reset.
`timescale 1ns/10ps
`default_nettype none
module sbd_sideband_sva
(
	// Clock and reset
	input wire logic                            clk,
	input wire logic                            rst_b,
	// Bus and loop events
	input wire sbd_pkg::sbd_wb_req_type         wb_req,
	input wire logic                            wb_ack_o,
	input wire sbd_pkg::sbd_loop_evt_type [1:0] loop_evt,
	// Pins and link controls
	input wire logic                            failure_lamp_n,
	input wire logic                            loop_skip_a_n,
	input wire logic                            loop_skip_b_n,
	input wire logic                            skip_indicator_a_n,
	input wire logic                            skip_indicator_b_n,
	input wire logic [1:0]                      loop_rx_enable,
	input wire logic [1:0]                      loop_tx_enable
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	// ****************************************************************
	// Properties
	// ****************************************************************
	AST_IND_A: assert property (skip_indicator_a_n == loop_skip_a_n)
		else $error("indicator a differs from skip a");
	AST_IND_B: assert property (skip_indicator_b_n == loop_skip_b_n)
		else $error("indicator b differs from skip b");
	AST_SKIP_A: assert property (loop_evt[0].skip_prim |=> !loop_skip_a_n)
		else $error("skip sequence did not skip port a");
	AST_FAIL_B: assert property ((|loop_evt[1][3:0]) |=> !loop_skip_b_n)
		else $error("port b failure did not skip port b");
	// Receiver stays on once out of reset, skipped or not
	AST_RX_ON: assert property ($past(rst_b) |-> loop_rx_enable == 2'h3)
		else $error("receiver disabled");
	AST_FAULT: assert property ((loop_evt[0].hw_err && loop_evt[1].hw_err) [*3]
		|-> !failure_lamp_n)
		else $error("fault lamp off with both ports failed");
	AST_TX_A: assert property (!loop_skip_a_n |=> !loop_tx_enable[0])
		else $error("transmitter on while port a skipped");
	AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	AST_ACK_NEXT: assert property (wb_req.cyc && wb_req.stb && !wb_ack_o |=> wb_ack_o)
		else $error("ack late");
	cover property (loop_evt[0].skip_prim);
	cover property ($rose(loop_skip_a_n));
	cover property (!failure_lamp_n);
	cover property (wb_ack_o && !wb_req.we);
endmodule

bind sbd_sideband sbd_sideband_sva sbd_sideband_sva_inst (.clk, .rst_b, .wb_req, .wb_ack_o,
	.loop_evt, .failure_lamp_n, .loop_skip_a_n, .loop_skip_b_n, .skip_indicator_a_n,
	.skip_indicator_b_n, .loop_rx_enable, .loop_tx_enable);
`default_nettype wire

// ==== bench/sbd_backplane_model.sv ====
// Backplane model: strap wiring, slot lines and external skip switches.
// Assumes the bench sets the slot and strap wiring before reset ends.
`timescale 1ns/10ps
`default_nettype none
module sbd_backplane_model
(
	// Clock and wiring
	input wire logic        clk,
	input wire logic [6:0]  slot_cfg,
	input wire logic [1:0]  strap_cfg,
	// Drive pins
	input wire logic        enclosure_side_channel_n,
	input wire logic        loop_skip_a_n,
	input wire logic        loop_skip_b_n,
	output logic [6:0]      slot_number,
	output logic            start_strap_1,
	output logic            start_strap_2,
	output logic [1:0]      external_skip_switch
);
	logic [6:0] pat_q = 7'h2a;

	// Pattern toggles so nothing stale passes
	always_ff @(posedge clk)
		pat_q <= ~pat_q;
	// Slot lines driven both ways, address only while side channel high
	assign slot_number = enclosure_side_channel_n ? slot_cfg : pat_q;
	assign start_strap_1 = strap_cfg[0];
	assign start_strap_2 = strap_cfg[1];
	// Pull-down makes a low or absent drive a bypass
	assign external_skip_switch = {!loop_skip_b_n, !loop_skip_a_n};
endmodule
`default_nettype wire

// ==== bench/drive_backplane_sideband_bench.sv ====
// Bench for the sideband block: lamps, loop skip, straps, slot number.
// Assumes the backplane model and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module drive_backplane_sideband_bench;
	localparam int TK = 2;
	logic                    clk, rst_b, step, esi_n, fl_n, al_n, ska_n, skb_n, ia_n, ib_n;
	logic                    ack, spin, hv, sreq, s1, s2;
	logic [1:0]              sw, scfg;
	logic [1:0][5:0]         evt;
	logic [6:0]              slot, scfg7, ha;
	logic [31:0]             q, dat;
	sbd_pkg::sbd_wb_req_type req;
	int                      bad_count, cmp_count, cyc_n, t0;

	sbd_sideband #(.TICK_CYCLES(TK)) sbd_sideband_inst (.clk(clk), .rst_b(rst_b),
		.wb_req(req), .wb_dat_o(dat), .wb_ack_o(ack), .loop_evt(evt), .cylinder_step(step),
		.start_strap_1(s1), .start_strap_2(s2), .slot_number(slot),
		.enclosure_side_channel_n(esi_n), .failure_lamp_n(fl_n), .activity_lamp_n(al_n),
		.loop_skip_a_n(ska_n), .loop_skip_b_n(skb_n), .skip_indicator_a_n(ia_n),
		.skip_indicator_b_n(ib_n), .loop_rx_enable(), .loop_tx_enable(), .spin_up_req(spin),
		.hard_address(ha), .hard_address_valid(hv), .soft_address_req(sreq));
	sbd_backplane_model sbd_backplane_model_inst (.clk(clk), .slot_cfg(scfg7),
		.strap_cfg(scfg), .enclosure_side_channel_n(esi_n), .loop_skip_a_n(ska_n),
		.loop_skip_b_n(skb_n), .slot_number(slot), .start_strap_1(s1), .start_strap_2(s2),
		.external_skip_switch(sw));

	// ****************************************************************
	// Clock and helpers
	// ****************************************************************
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) cyc_n <= cyc_n + 1;

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		cmp_count++;
		if (s !== e)
		begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic end_of_test();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// One classic cycle; request held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		req <= {1'b1, 1'b1, w, 4'hf, a, d};
		for (k = 0; k < 9 && ack !== 1'b1; k++)
			@(posedge clk);
		q = dat;
		req <= '0;
		if (k == 9)
		begin
			bad_count++;
			end_of_test();
		end
	endtask
	task automatic ctl(input logic [31:0] d);
		wb(1'b1, 8'h00, d);
		repeat (2) @(posedge clk);
	endtask
	// Field f: 0 is skip_prim, the top bit
	task automatic ev(input int p, input int f);
		@(posedge clk);
		evt[p] <= 6'h20 >> f;
		@(posedge clk);
		evt[p] <= 6'h00;
		repeat (2) @(posedge clk);
	endtask
	task automatic do_reset(input logic [6:0] s, input logic [1:0] st);
		@(posedge clk);
		rst_b <= 1'b0;
		scfg7 <= s;
		scfg <= st;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		t0 = cyc_n;
		repeat (8) @(posedge clk);
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_boot();
		chk("skip pins", 32'h0, {ska_n, skb_n, ia_n, ib_n});
		chk("idle pins", 32'h3, {esi_n, fl_n});
		wb(1'b0, 8'h04, 32'h0);
		chk("status", 32'h00890209, q & 32'h00ff0fff);
		chk("address", 32'h109, {hv, sreq, ha});
		wb(1'b0, 8'h08, 32'h0);
		chk("unmapped", 32'h0, q);
		$display("boot test done");
	endtask
	task automatic t_skip();
		ev(0, 1);
		chk("skip held", 32'h0, ska_n);
		ctl(32'h4);
		for (int i = 0; i < 5; i++)
		begin
			ev(0, 1);
			ev(1, 1);
			chk("released", 32'hf, {ska_n, skb_n, ia_n, ib_n});
			chk("switch", 32'h0, sw);
			ev(i % 2, i == 4 ? 0 : i + 2);
			chk("skipped", 32'h0, i % 2 ? skb_n : ska_n);
		end
		$display("skip test done");
	endtask
	task automatic t_fault();
		for (int i = 0; i < 2; i++)
		begin
			ctl(32'h4 | (32'h1 << i));
			chk("fault lamp", 32'h0, fl_n);
		end
		ctl(32'h4);
		@(posedge clk);
		evt <= {6'h01, 6'h01};
		repeat (4) @(posedge clk);
		evt <= '0;
		repeat (2) @(posedge clk);
		chk("both failed", 32'h0, fl_n);
		ev(0, 1);
		ev(1, 1);
		chk("fault clear", 32'h1, fl_n);
		$display("fault test done");
	endtask
	// Steady states first, then one full period of each blink
	task automatic t_lamp();
		logic [31:0] cv[6] = '{32'h0c, 32'h44, 32'h4c, 32'h04, 32'h24, 32'h64};
		int          per[6] = '{100, 100, 100, 2000, 500, 500};
		int          exp_on[6] = '{200, 200, 0, 800, 500, 500};
		int          on;
		for (int j = 0; j < 6; j++)
		begin
			ctl(cv[j]);
			on = 0;
			repeat (per[j] * TK) @(posedge clk) on += (al_n === 1'b0);
			chk("lamp on cycles", exp_on[j], on);
		end
		$display("lamp test done");
	endtask
	task automatic t_format();
		logic x;
		ctl(32'h34);
		x = al_n;
		for (int i = 0; i < 2; i++)
		begin
			@(posedge clk);
			step <= 1'b1;
			@(posedge clk);
			step <= 1'b0;
			repeat (600) @(posedge clk);
			x = ~x;
			chk("format lamp", x, al_n);
		end
		ctl(32'h84);
		chk("side channel low", 32'h0, esi_n);
		ctl(32'h04);
		chk("side channel high", 32'h1, esi_n);
		$display("format test done");
	endtask
	task automatic t_spin();
		int k;
		for (k = 0; k < 30000 && spin !== 1'b1; k++)
			@(posedge clk);
		chk("stagger", 32'h1, (cyc_n - t0) >= 23990 && (cyc_n - t0) <= 24020);
		if (k == 30000)
			end_of_test();
		for (int i = 0; i < 2; i++)
		begin
			do_reset(i ? 7'h7f : 7'h7e, i ? 2'h2 : 2'h3);
			wb(1'b0, 8'h04, 32'h0);
			chk("slot kind", i ? 32'h9 : 32'he, q[10:7]);
			chk("soft request", i, {hv, sreq});
			wb(1'b1, 8'h00, 32'h100);
			repeat (4) @(posedge clk);
			chk("command start", i, spin);
		end
		$display("spin test done");
	endtask

	initial
	begin
		rst_b = 1'b0;
		req = '0;
		evt = '0;
		step = 1'b0;
		scfg7 = 7'h09;
		scfg = 2'h1;
		cyc_n = 0;
		do_reset(7'h09, 2'h1);
		t_boot();
		t_skip();
		t_fault();
		t_lamp();
		t_format();
		t_spin();
		end_of_test();
	end
endmodule
`default_nettype wire
